// File: hdl/net_switch_decoder.sv
// switch decoder of one network: tap select and terminal switches
`timescale 1ns/100ps
`include "wiper_terminal_params.svh"

module net_switch_decoder
  import wiper_terminal_pkg::*;
#(
  parameter  int WIPER_BITS = 8,
  localparam int TAPS       = (1 << WIPER_BITS) + 1
) (
  input  wire logic            clk,
  input  wire logic            nrst,
  input  wire net_ctrl_t       ctrl,
  input  wire wiper_t          wiper,
  output      switch_t         sw,
  output      logic [TAPS-1:0] tap_sel
);

  // ============================================================
  // constants and state
  localparam wiper_t          FULL    = wiper_t'(1) << WIPER_BITS;
  localparam logic [TAPS-1:0] TAP_ONE = {{(TAPS-1){1'b0}}, 1'b1};
  localparam logic [TAPS-1:0] TAP_MID = TAP_ONE << (TAPS / 2);

  typedef struct packed {
    switch_t         sw;
    logic [TAPS-1:0] tap;
  } dec_state_t;

  localparam dec_state_t RESET_ST = '{sw: switch_t'(3'b111), tap: TAP_MID};

  dec_state_t            st;
  dec_state_t            next_st;
  logic [WIPER_BITS:0]   code;
  logic [TAPS-1:0]       onehot;

  // ============================================================
  // tap code, clamped above full scale
  assign code = (wiper >= FULL) ? FULL[WIPER_BITS:0] : wiper[WIPER_BITS:0];

  for (genvar i = 0; i < TAPS; i++) begin : g_tap
    assign onehot[i] = (code == (WIPER_BITS+1)'(i));
  end

  // ============================================================
  // switch state
  always_comb begin
    next_st = st;
    if (!ctrl.net_shutdown_force) begin
      next_st.sw.term_a_sw = 1'b0;
      next_st.sw.wiper_sw  = 1'b1;
      next_st.sw.term_b_sw = 1'b1;
      next_st.tap          = TAP_ONE;
    end else begin
      next_st.sw.term_a_sw = ctrl.net_term_a_connect;
      next_st.sw.wiper_sw  = ctrl.net_wiper_connect;
      next_st.sw.term_b_sw = ctrl.net_term_b_connect;
      next_st.tap          = onehot;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st <= RESET_ST;
    end else begin
      st <= next_st;
    end
  end

  assign sw      = st.sw;
  assign tap_sel = st.tap;

  // ============================================================
  // checks
  tap_onehot_a : assert property (@(posedge clk) disable iff (!nrst)
    $onehot(tap_sel)) else $error("tap select not one-hot");

  shutdown_map_a : assert property (@(posedge clk) disable iff (!nrst)
    !ctrl.net_shutdown_force |=> tap_sel[0] && !sw.term_a_sw && sw.wiper_sw && sw.term_b_sw)
    else $error("shutdown map wrong");

  zero_scale_a : assert property (@(posedge clk) disable iff (!nrst)
    (ctrl.net_shutdown_force && wiper == '0) |=> tap_sel[0])
    else $error("zero scale tap wrong");

  full_scale_a : assert property (@(posedge clk) disable iff (!nrst)
    (ctrl.net_shutdown_force && wiper >= FULL) |=> tap_sel[TAPS-1])
    else $error("full scale tap wrong");

  connect_follow_a : assert property (@(posedge clk) disable iff (!nrst)
    ctrl.net_shutdown_force |=> sw.term_a_sw == $past(ctrl.net_term_a_connect)
      && sw.term_b_sw == $past(ctrl.net_term_b_connect))
    else $error("connect bits not followed");

endmodule : net_switch_decoder

// File: hdl/wiper_terminal_control.sv
// terminal control and wiper register bank of four potentiometer networks
//
// What this block does
// - bit 8 reads one, writes ignored
// - shutdown force zero forces network shutdown
// - terminal A connect bit switches A
// - wiper connect bit switches wiper
// - terminal B connect bit switches B
// - terminal control writes never touch wipers
// - four networks, two per control register
// - 8-bit gives 257, 7-bit 129 positions
// - wiper value closes exactly one tap
// - wiper zero ties wiper to B
// - full scale ties wiper to A
// - values above full scale act as full
// - over-range ignores increment and decrement
// - shutdown only through control register bits
// - reset loads all ones into both registers
// - new value applies once command completes
// - shutdown overrides, preserves connect bits
`timescale 1ns/100ps
`include "wiper_terminal_params.svh"

module wiper_terminal_control
  import wiper_terminal_pkg::*;
#(
  parameter  int WIPER_BITS = 8,
  localparam int TAPS       = (1 << WIPER_BITS) + 1
) (
  input  wire logic                  clk,
  input  wire logic                  nrst,
  input  wire logic [7:0]            address,
  input  wire logic                  read,
  input  wire logic                  write,
  input  wire logic [31:0]           writedata,
  input  wire logic [3:0]            byteenable,
  output      logic [31:0]           readdata,
  output      logic                  waitrequest,
  output      switch_t [3:0]         net_sw,
  output      logic [3:0][TAPS-1:0]  net_tap_sel
);

  // ============================================================
  // parameter check
  if (WIPER_BITS != 7 && WIPER_BITS != 8) begin : g_bad_bits
    $error("WIPER_BITS must be 7 or 8");
  end

  // ============================================================
  // constants
  localparam wiper_t FULL = wiper_t'(1) << WIPER_BITS;
  localparam wiper_t MID  = FULL >> 1;

  localparam bank_state_t RESET_ST = '{
    bus:                 BUS_IDLE,
    rdata:               32'h0000_0000,
    terminal_control_lo: `TC_RESET_VALUE,
    terminal_control_hi: `TC_RESET_VALUE,
    wiper:               {MID, MID, MID, MID}
  };

  // ============================================================
  // state and decode signals
  bank_state_t      st;
  bank_state_t      next_st;
  logic [31:0]      be_mask;
  logic             take;
  logic             hit_wiper;
  logic [1:0]       wiper_idx;
  logic [7:0]       wiper_off;
  logic             cmd_take;
  logic [1:0]       cmd_net;
  logic             cmd_inc;
  logic             cmd_dec;
  net_ctrl_t [3:0]  net_ctrl;
  logic [3:0]       hard_power_down_pin_active;
  logic [3:0]       over_range;

  assign be_mask   = {{8{byteenable[3]}}, {8{byteenable[2]}},
                      {8{byteenable[1]}}, {8{byteenable[0]}}};
  assign take      = (st.bus == BUS_ANSWER) && (read || write);
  assign wiper_off = address - `WIPER_BASE_OFFSET;
  assign hit_wiper = (address >= `WIPER_BASE_OFFSET) && (address <= `WIPER_LAST_OFFSET)
                     && (address[1:0] == 2'b00);
  assign wiper_idx = wiper_off[3:2];
  assign cmd_take  = take && write && (address == `WIPER_CMD_OFFSET) && byteenable[0];
  assign cmd_net   = writedata[`CMD_NET_LSB +: 2];
  assign cmd_inc   = writedata[`CMD_INC_POS];
  assign cmd_dec   = writedata[`CMD_DEC_POS];

  // ============================================================
  // network control nibbles and status
  for (genvar n = 0; n < 4; n++) begin : g_net
    localparam int NIB = (n % 2) * `NIBBLE_WIDTH;
    if (n < 2) begin : g_lo
      assign net_ctrl[n] = st.terminal_control_lo[NIB +: `NIBBLE_WIDTH];
    end else begin : g_hi
      assign net_ctrl[n] = st.terminal_control_hi[NIB +: `NIBBLE_WIDTH];
    end
    assign hard_power_down_pin_active[n] = !net_ctrl[n].net_shutdown_force;
    assign over_range[n]  = st.wiper[n] > FULL;

    net_switch_decoder #(
      .WIPER_BITS (WIPER_BITS)
    ) u_dec (
      .clk     (clk),
      .nrst    (nrst),
      .ctrl    (net_ctrl[n]),
      .wiper   (st.wiper[n]),
      .sw      (net_sw[n]),
      .tap_sel (net_tap_sel[n])
    );
  end

  // ============================================================
  // wiper step with range limits
  function automatic wiper_t step_wiper(input wiper_t w, input logic inc, input logic dec);
    wiper_t r;
    r = w;
    if (w > FULL) begin
      r = w;
    end else if (inc && !dec && w != FULL) begin
      r = wiper_t'(w + 10'h001);
    end else if (dec && !inc && w != '0) begin
      r = wiper_t'(w - 10'h001);
    end
    return r;
  endfunction : step_wiper

  // ============================================================
  // read multiplexer
  function automatic logic [31:0] read_value(input logic [7:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    if (a == `TC_LO_OFFSET) begin
      v = {23'h000000, st.terminal_control_lo};
    end else if (a == `TC_HI_OFFSET) begin
      v = {23'h000000, st.terminal_control_hi};
    end else if (hit_wiper) begin
      v = {22'h000000, st.wiper[wiper_idx]};
    end else if (a == `STATUS_OFFSET) begin
      v = {24'h000000, over_range, hard_power_down_pin_active};
    end
    return v;
  endfunction : read_value

  // ============================================================
  // bus slave and register updates
  always_comb begin
    logic [31:0] merged;
    merged  = 32'h0000_0000;
    next_st = st;
    case (st.bus)
      BUS_IDLE: begin
        if (read || write) begin
          next_st.bus   = BUS_ANSWER;
          next_st.rdata = read ? read_value(address) : 32'h0000_0000;
        end
      end
      BUS_ANSWER: begin
        next_st.bus = BUS_IDLE;
        if (write) begin
          if (address == `TC_LO_OFFSET) begin
            merged = ({23'h000000, st.terminal_control_lo} & ~be_mask) | (writedata & be_mask);
            next_st.terminal_control_lo = {1'b1, merged[7:0]};
          end else if (address == `TC_HI_OFFSET) begin
            merged = ({23'h000000, st.terminal_control_hi} & ~be_mask) | (writedata & be_mask);
            next_st.terminal_control_hi = {1'b1, merged[7:0]};
          end else if (hit_wiper) begin
            merged = ({22'h000000, st.wiper[wiper_idx]} & ~be_mask) | (writedata & be_mask);
            next_st.wiper[wiper_idx] = merged[9:0];
          end else if (cmd_take) begin
            next_st.wiper[cmd_net] = step_wiper(st.wiper[cmd_net], cmd_inc, cmd_dec);
          end
        end
      end
      default: begin
        next_st.bus = BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st <= RESET_ST;
    end else begin
      st <= next_st;
    end
  end

  assign waitrequest = (read || write) && (st.bus == BUS_IDLE);
  assign readdata    = st.rdata;

  // ============================================================
  // checks
  reserved_top_a : assert property (@(posedge clk) disable iff (!nrst)
    st.terminal_control_lo[`RESERVED_TOP_POS] && st.terminal_control_hi[`RESERVED_TOP_POS])
    else $error("reserved top bit not one");

  one_wait_a : assert property (@(posedge clk) disable iff (!nrst)
    (read || write) && waitrequest |=> !waitrequest || !(read || write))
    else $error("more than one wait state");

  tc_write_a : assert property (@(posedge clk) disable iff (!nrst)
    (take && write && address == `TC_LO_OFFSET && byteenable[0])
      |=> st.terminal_control_lo[7:0] == $past(writedata[7:0]))
    else $error("control write not stored");

  tc_keeps_wiper_a : assert property (@(posedge clk) disable iff (!nrst)
    (take && write && (address == `TC_LO_OFFSET || address == `TC_HI_OFFSET))
      |=> $stable(st.wiper))
    else $error("control write changed a wiper");

  no_early_apply_a : assert property (@(posedge clk) disable iff (!nrst)
    (write && waitrequest) |=> $stable(st.terminal_control_lo) && $stable(st.terminal_control_hi))
    else $error("write applied before completion");

  over_hold_a : assert property (@(posedge clk) disable iff (!nrst)
    (cmd_take && st.wiper[cmd_net] > FULL) |=> $stable(st.wiper))
    else $error("over-range wiper stepped");

  limit_hold_a : assert property (@(posedge clk) disable iff (!nrst)
    (cmd_take && ((cmd_inc && st.wiper[cmd_net] == FULL) || (cmd_dec && st.wiper[cmd_net] == '0)))
      |=> $stable(st.wiper))
    else $error("wiper stepped past a limit");

  inc_step_a : assert property (@(posedge clk) disable iff (!nrst)
    (cmd_take && cmd_inc && !cmd_dec && st.wiper[cmd_net] < FULL)
      |=> st.wiper[$past(cmd_net)] == $past(st.wiper[cmd_net]) + 10'h001)
    else $error("increment did not step by one");

  hard_power_down_pin_status_a : assert property (@(posedge clk) disable iff (!nrst)
    hard_power_down_pin_active[0] |=> !net_sw[0].term_a_sw && net_tap_sel[0][0])
    else $error("shutdown status and switches disagree");

  tc_hi_write_a : assert property (@(posedge clk) disable iff (!nrst)
    (take && write && address == `TC_HI_OFFSET && byteenable[0])
      |=> st.terminal_control_hi[7:0] == $past(writedata[7:0]))
    else $error("upper control write not stored");

  hi_keeps_lo_a : assert property (@(posedge clk) disable iff (!nrst)
    (take && write && address == `TC_HI_OFFSET) |=> $stable(st.terminal_control_lo))
    else $error("upper control write changed lower");

  lo_keeps_hi_a : assert property (@(posedge clk) disable iff (!nrst)
    (take && write && address == `TC_LO_OFFSET) |=> $stable(st.terminal_control_hi))
    else $error("lower control write changed upper");

  wiper_write_a : assert property (@(posedge clk) disable iff (!nrst)
    (take && write && hit_wiper && byteenable[1:0] == 2'b11)
      |=> st.wiper[$past(wiper_idx)] == $past(writedata[9:0]))
    else $error("wiper write not stored");

  wiper_keeps_tc_a : assert property (@(posedge clk) disable iff (!nrst)
    (take && write && (hit_wiper || cmd_take))
      |=> $stable(st.terminal_control_lo) && $stable(st.terminal_control_hi))
    else $error("wiper access changed control bits");

  dec_step_a : assert property (@(posedge clk) disable iff (!nrst)
    (cmd_take && cmd_dec && !cmd_inc
      && st.wiper[cmd_net] != '0 && st.wiper[cmd_net] <= FULL)
      |=> st.wiper[$past(cmd_net)] == $past(st.wiper[cmd_net]) - 10'h001)
    else $error("decrement did not step by one");

  both_cmd_a : assert property (@(posedge clk) disable iff (!nrst)
    (cmd_take && cmd_inc == cmd_dec) |=> $stable(st.wiper))
    else $error("ambiguous command stepped a wiper");

  cmd_lane_a : assert property (@(posedge clk) disable iff (!nrst)
    (take && write && address == `WIPER_CMD_OFFSET && !byteenable[0])
      |=> $stable(st.wiper))
    else $error("command without low lane stepped a wiper");

  answer_once_a : assert property (@(posedge clk) disable iff (!nrst)
    st.bus == BUS_ANSWER |=> st.bus == BUS_IDLE)
    else $error("bus answer lasted over one cycle");

  readdata_hold_a : assert property (@(posedge clk) disable iff (!nrst)
    !(read || write) |=> $stable(readdata))
    else $error("read data changed without request");

  read_lo_a : assert property (@(posedge clk) disable iff (!nrst)
    (read && st.bus == BUS_IDLE && address == `TC_LO_OFFSET)
      |=> readdata == {23'h0, $past(st.terminal_control_lo)})
    else $error("lower control read wrong");

  read_hi_a : assert property (@(posedge clk) disable iff (!nrst)
    (read && st.bus == BUS_IDLE && address == `TC_HI_OFFSET)
      |=> readdata == {23'h0, $past(st.terminal_control_hi)})
    else $error("upper control read wrong");

  read_wiper_a : assert property (@(posedge clk) disable iff (!nrst)
    (read && st.bus == BUS_IDLE && hit_wiper)
      |=> readdata == {22'h0, $past(st.wiper[wiper_idx])})
    else $error("wiper read wrong");

  read_status_a : assert property (@(posedge clk) disable iff (!nrst)
    (read && st.bus == BUS_IDLE && address == `STATUS_OFFSET)
      |=> readdata == {24'h0, $past(over_range), $past(hard_power_down_pin_active)})
    else $error("status read wrong");

  read_cmd_a : assert property (@(posedge clk) disable iff (!nrst)
    (read && st.bus == BUS_IDLE && address == `WIPER_CMD_OFFSET)
      |=> readdata == 32'h0000_0000)
    else $error("command register read not zero");

  unmapped_write_a : assert property (@(posedge clk) disable iff (!nrst)
    (take && write && address >= `STATUS_OFFSET)
      |=> $stable(st.wiper) && $stable(st.terminal_control_lo)
        && $stable(st.terminal_control_hi))
    else $error("write to status or unmapped space took effect");

  lane_mask_a : assert property (@(posedge clk) disable iff (!nrst)
    (take && write && address == `TC_LO_OFFSET && !byteenable[0])
      |=> $stable(st.terminal_control_lo))
    else $error("disabled byte lane written");

  // ============================================================
  // per-network checks
  for (genvar n = 0; n < 4; n++) begin : g_net_chk
    net_connect_a : assert property (@(posedge clk) disable iff (!nrst)
      !hard_power_down_pin_active[n] |=> net_sw[n] == switch_t'({$past(net_ctrl[n].net_term_a_connect),
        $past(net_ctrl[n].net_wiper_connect), $past(net_ctrl[n].net_term_b_connect)}))
      else $error("network switches do not follow connect bits");

    net_shutdown_a : assert property (@(posedge clk) disable iff (!nrst)
      hard_power_down_pin_active[n] |=> net_sw[n] == switch_t'(3'b011) && net_tap_sel[n][0])
      else $error("network shutdown map wrong");

    net_full_a : assert property (@(posedge clk) disable iff (!nrst)
      (!hard_power_down_pin_active[n] && st.wiper[n] >= FULL) |=> net_tap_sel[n][TAPS-1])
      else $error("network full scale tap wrong");

    net_zero_a : assert property (@(posedge clk) disable iff (!nrst)
      (!hard_power_down_pin_active[n] && st.wiper[n] == '0) |=> net_tap_sel[n][0])
      else $error("network zero scale tap wrong");

    net_tap_a : assert property (@(posedge clk) disable iff (!nrst)
      (!hard_power_down_pin_active[n] && st.wiper[n] < FULL)
        |=> net_tap_sel[n][$past(st.wiper[n][WIPER_BITS-1:0])])
      else $error("network tap does not follow wiper");

    net_onehot_a : assert property (@(posedge clk) disable iff (!nrst)
      $onehot(net_tap_sel[n])) else $error("network tap select not one-hot");

    cmd_other_net_a : assert property (@(posedge clk) disable iff (!nrst)
      (cmd_take && cmd_net != 2'(n)) |=> $stable(st.wiper[n]))
      else $error("command stepped another network");
  end

endmodule : wiper_terminal_control

// File: hdl/wiper_terminal_params.svh
// offsets, field positions, reset values and limits of the wiper terminal bank
`ifndef WIPER_TERMINAL_PARAMS_SVH
`define WIPER_TERMINAL_PARAMS_SVH

// ============================================================
// register byte offsets
`define TC_LO_OFFSET      8'h00
`define TC_HI_OFFSET      8'h04
`define WIPER_BASE_OFFSET 8'h08
`define WIPER_LAST_OFFSET 8'h14
`define WIPER_CMD_OFFSET  8'h18
`define STATUS_OFFSET     8'h1c

// ============================================================
// terminal control fields, per nibble
`define NIBBLE_WIDTH      4
`define RESERVED_TOP_POS  8
`define HARD_POWER_DOWN_PIN_FORCE_POS    3
`define TERM_A_POS        2
`define WIPER_CONN_POS    1
`define TERM_B_POS        0
`define TC_RESET_VALUE    9'h1ff

// ============================================================
// wiper command fields and limits
`define CMD_INC_POS       0
`define CMD_DEC_POS       1
`define CMD_NET_LSB       4
`define WIPER_MAX_VALUE   10'h3ff
`define STATUS_OVER_LSB   4

`endif

// File: hdl/wiper_terminal_pkg.sv
// types shared by the wiper terminal bank and its switch decoder
package wiper_terminal_pkg;

  // ============================================================
  // register and field types
  typedef logic [8:0] tc_reg_t;
  typedef logic [9:0] wiper_t;

  typedef struct packed {
    logic net_shutdown_force;
    logic net_term_a_connect;
    logic net_wiper_connect;
    logic net_term_b_connect;
  } net_ctrl_t;

  typedef struct packed {
    logic term_a_sw;
    logic wiper_sw;
    logic term_b_sw;
  } switch_t;

  // ============================================================
  // bus state and bank state
  typedef enum logic [0:0] {
    BUS_IDLE   = 1'b0,
    BUS_ANSWER = 1'b1
  } bus_state_t;

  typedef struct packed {
    bus_state_t       bus;
    logic [31:0]      rdata;
    tc_reg_t          terminal_control_lo;
    tc_reg_t          terminal_control_hi;
    wiper_t [3:0]     wiper;
  } bank_state_t;

endpackage : wiper_terminal_pkg

// File: verif/host_master.sv
// bus master model of the host that issues register commands
`timescale 1ns/100ps

module host_master (
  input  wire logic        clk,
  input  wire logic [31:0] readdata,
  input  wire logic        waitrequest,
  output      logic [7:0]  address,
  output      logic        read,
  output      logic        write,
  output      logic [31:0] writedata,
  output      logic [3:0]  byteenable
);
  initial begin
    address    = 8'h00;
    read       = 1'b0;
    write      = 1'b0;
    writedata  = 32'h0;
    byteenable = 4'h0;
  end

  // ============================================================
  // one transfer, held until waitrequest is sampled low
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    address    <= a;
    writedata  <= d;
    byteenable <= 4'hf;
    write      <= w;
    read       <= !w;
    do @(posedge clk); while (waitrequest !== 1'b0);
    q = readdata;
    write      <= 1'b0;
    read       <= 1'b0;
    writedata  <= ~d;
    @(posedge clk);
  endtask : xfer
endmodule : host_master

// File: verif/test_wiper_terminal_control.sv
// self-checking bench of the wiper terminal bank
`timescale 1ns/100ps

module test_wiper_terminal_control;
  import wiper_terminal_pkg::*;
  localparam int TAPS = 257;

  logic                 clk = 1'b0;
  logic                 nrst;
  logic [7:0]           address;
  logic                 read;
  logic                 write;
  logic [31:0]          writedata;
  logic [3:0]           byteenable;
  logic [31:0]          readdata;
  logic                 waitrequest;
  switch_t [3:0]        net_sw;
  logic [3:0][TAPS-1:0] net_tap_sel;
  logic [31:0]          q;
  int                   failures = 0;
  int                   checks_done = 0;
  int                   cycles = 0;

  always #12.5 clk = ~clk;

  host_master host (
    .clk(clk), .readdata(readdata), .waitrequest(waitrequest), .address(address),
    .read(read), .write(write), .writedata(writedata), .byteenable(byteenable)
  );

  wiper_terminal_control #(.WIPER_BITS(8)) uut (
    .clk(clk), .nrst(nrst), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .net_sw(net_sw), .net_tap_sel(net_tap_sel)
  );

  // ============================================================
  // compare, bus and step helpers
  task automatic chk(input logic [259:0] seen, input logic [259:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, q);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    host.xfer(1'b0, a, 32'h0, q);
    chk(260'(q), 260'(e));
  endtask : rdc

  task automatic swc(input int n, input logic [2:0] s, input int t);
    @(negedge clk);
    chk(260'(net_sw[n]), 260'(s));
    chk(260'(net_tap_sel[n]), 260'(1) << t);
    @(posedge clk);
  endtask : swc

  // load a wiper, issue one step command, check value and tap
  task automatic step(input int n, input logic [2:0] s, input logic [9:0] v,
                      input logic [1:0] c, input logic [9:0] e, input int t);
    wr(8'(8 + 4 * n), {22'h0, v});
    wr(8'h18, {26'h0, 2'(n), 2'b00, c});
    rdc(8'(8 + 4 * n), {22'h0, e});
    swc(n, s, t);
  endtask : step

  task automatic print_verdict;
    if (failures == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : print_verdict

  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      print_verdict();
    end
  end

  // ============================================================
  // test sequence
  initial begin
    nrst = 1'b0;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rdc(8'h00, 32'h1ff);
    rdc(8'h04, 32'h1ff);
    for (int n = 0; n < 4; n++) begin
      rdc(8'(8 + 4 * n), 32'h080);
      swc(n, 3'b111, 128);
    end
    chk(260'($bits(net_tap_sel[0])), 260'(257));
    wr(8'h00, 32'h000);
    rdc(8'h00, 32'h100);
    swc(0, 3'b011, 0);
    swc(1, 3'b011, 0);
    rdc(8'h1c, 32'h003);
    wr(8'h00, 32'h0ac);
    rdc(8'h00, 32'h1ac);
    swc(0, 3'b100, 128);
    swc(1, 3'b010, 128);
    wr(8'h04, 32'h0d9);
    rdc(8'h04, 32'h1d9);
    swc(2, 3'b001, 128);
    swc(3, 3'b101, 128);
    rdc(8'h14, 32'h080);
    wr(8'h00, 32'h0ff);
    step(0, 3'b111, 10'h100, 2'b01, 10'h100, 256);
    step(0, 3'b111, 10'h100, 2'b10, 10'h0ff, 255);
    step(0, 3'b111, 10'h000, 2'b10, 10'h000, 0);
    step(0, 3'b111, 10'h000, 2'b01, 10'h001, 1);
    step(0, 3'b111, 10'h101, 2'b01, 10'h101, 256);
    step(0, 3'b111, 10'h3ff, 2'b10, 10'h3ff, 256);
    rdc(8'h1c, 32'h010);
    step(3, 3'b101, 10'h050, 2'b01, 10'h051, 81);
    step(2, 3'b001, 10'h0c0, 2'b10, 10'h0bf, 191);
    wr(8'h08, 32'h050);
    wr(8'h00, 32'h0f7);
    swc(0, 3'b011, 0);
    rdc(8'h08, 32'h050);
    rdc(8'h00, 32'h1f7);
    wr(8'h00, 32'h0ff);
    swc(0, 3'b111, 80);
    rdc(8'h20, 32'h0);
    print_verdict();
  end
endmodule : test_wiper_terminal_control
